// file: design/ssw_pkg.sv
// Package for the slave state machine and watchdog block.
// Assumes a single 25 MHz clock domain and a plain register port.
package ssw_pkg;
	// Clock and tick timing
	localparam int CLK_HZ = 25000000;
	localparam int BASE_PERIOD_NS = 1000000000 / CLK_HZ;
	localparam logic [15:0] PRESCALE_RST = 16'h09C2;
	localparam logic [15:0] PRESCALE_EXTRA = 16'h0002;
	localparam logic [15:0] SYNC_WD_RST = 16'h03E8;
	localparam logic [15:0] LOCAL_WD_RST = 16'h03E8;
	localparam int TICK_US = 100;
	localparam int WD_TIMEOUT_MS = 100;
	// Register word offsets (byte addresses)
	localparam logic [7:0] REG_PRESCALE = 8'h00;
	localparam logic [7:0] REG_SYNC_WD = 8'h04;
	localparam logic [7:0] REG_LOCAL_WD = 8'h08;
	localparam logic [7:0] REG_STATE_REQ = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_SETUP = 8'h14;
	// Setup register fields, written by the master before transitions
	localparam int SETUP_MBX_OK = 0;
	localparam int SETUP_PD_OK = 1;
	localparam int SETUP_DC_OK = 2;
	// Status register fields
	localparam int ST_STATE_LSB = 0;
	localparam int ST_ERR = 4;
	localparam int ST_SYNC_EXP = 5;
	localparam int ST_LOCAL_EXP = 6;
	// State request codes
	localparam logic [2:0] REQ_INIT = 3'h1;
	localparam logic [2:0] REQ_CONFIG = 3'h2;
	localparam logic [2:0] REQ_BOOT = 3'h3;
	localparam logic [2:0] REQ_INPUTS = 3'h4;
	localparam logic [2:0] REQ_FULL = 3'h0;

	typedef enum logic [2:0] {
		SSW_INIT,
		SSW_CONFIG,
		SSW_INPUTS,
		SSW_FULL,
		SSW_BOOT
	} ssw_state_t;

	typedef struct packed {
		logic mbx_ok;
		logic file_mbx_ok;
		logic pd_ok;
		logic outputs_live;
	} ssw_perm_t;
endpackage : ssw_pkg

// file: design/ssw_slave_ctrl.sv
// Slave state machine with sync-unit and local-side watchdogs.
// Assumes a register port on ref_clk_i; traffic strobes come from same-clock logic.

// Functional notes
// R1: Tick equals prescaler plus two base periods
// R2: Prescaler default 2498 gives 100 us tick
// R3: Shared prescaler, separate count per watchdog
// R4: Sync-unit watchdog default count 1000
// R5: Counts 0..65535, prescaler 1..65535 accepted
// R6: Only process-data access restarts sync watchdog
// R7: Sync expiry clears outputs, state unchanged
// R8: Local watchdog fires without local exchange
// R9: Sync count zero disables that watchdog
// R10: Master writes settings only if manual selected
// R11: Power-on Init refuses mailbox and process data
// R12: Master sets mailbox channels while in Init
// R13: Init to config checks mailbox setup
// R14: Config state allows mailbox, blocks process data
// R15: Master sets process-data channels in config
// R16: Inputs state entry checks setup, copies inputs
// R17: Inputs state exchanges data, outputs held safe; code passes master outputs there when sync count is zero
// R18: Master writes valid outputs before full request
// R19: Full state drives master outputs to pins
// R20: Boot only from Init, file mailbox only
// R21: Failed check refuses, stays, flags error
module ssw_slave_ctrl
	import ssw_pkg::*;
#(
	parameter int OUT_W = 8,
	parameter int IN_W = 8
) (
	// Clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic clk_en_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// Traffic events
	input wire logic pd_access_ok_i,
	input wire logic local_xchg_i,
	// Process data
	input wire logic [OUT_W-1:0] master_out_i,
	input wire logic [IN_W-1:0] field_in_i,
	output logic [OUT_W-1:0] field_out_o,
	output logic [IN_W-1:0] dpm_in_o,
	// Permissions and watchdog state
	output ssw_perm_t perm_o,
	output logic sync_wd_exp_o,
	output logic local_wd_exp_o
);
	logic [15:0] prescale_r;
	logic [15:0] sync_cnt_cfg_r;
	logic [15:0] local_cnt_cfg_r;
	logic [2:0] setup_r;
	logic [15:0] pre_cnt_r;
	logic tick;
	logic [15:0] sync_cnt_r;
	logic [15:0] local_cnt_r;
	logic sync_exp_r;
	logic local_exp_r;
	logic err_r;
	ssw_state_t state_r;
	logic [IN_W-1:0] field_in_s1_r;
	logic [IN_W-1:0] field_in_s2_r;
	logic [IN_W-1:0] dpm_in_r;
	logic [OUT_W-1:0] field_out_r;
	logic [31:0] rdata_r;
	logic req_wr;
	logic [2:0] req_code;

	assign req_wr = clk_en_i && reg_wr_i && (reg_addr_i == REG_STATE_REQ);
	assign req_code = reg_wdata_i[2:0];

	// Configuration registers; a zero prescaler is refused since it is out of range
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prescale_r <= PRESCALE_RST; // [R2]
			sync_cnt_cfg_r <= SYNC_WD_RST; // [R4]
			local_cnt_cfg_r <= LOCAL_WD_RST; // [R8]
			setup_r <= 3'h0;
		end else if (clk_en_i && reg_wr_i) begin
			if (reg_addr_i == REG_PRESCALE && reg_wdata_i[15:0] != 16'h0000) begin
				prescale_r <= reg_wdata_i[15:0]; // [R5]
			end
			if (reg_addr_i == REG_SYNC_WD) begin
				sync_cnt_cfg_r <= reg_wdata_i[15:0]; // [R5]
			end
			if (reg_addr_i == REG_LOCAL_WD) begin
				local_cnt_cfg_r <= reg_wdata_i[15:0];
			end
			if (reg_addr_i == REG_SETUP) begin
				setup_r <= reg_wdata_i[2:0];
			end
		end
	end

	// Shared prescaler: one tick every prescale+2 base periods, none at prescale 65535
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pre_cnt_r <= 16'h0000;
		end else if (clk_en_i) begin
			if (tick) begin
				pre_cnt_r <= 16'h0000;
			end else begin
				pre_cnt_r <= pre_cnt_r + 16'h0001;
			end
		end
	end
	// Compare in 17 bits; at prescale 65535 the 16-bit counter never reaches the end, so no tick
	// Greater-or-equal, so lowering the prescaler cannot strand the counter past its end
	assign tick = ({1'b0, pre_cnt_r} + 17'h00001) >=
		({1'b0, prescale_r} + {1'b0, PRESCALE_EXTRA}); // [R1] [R3]

	// Sync-unit watchdog
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync_cnt_r <= 16'h0000;
			sync_exp_r <= 1'b0;
		end else if (clk_en_i) begin
			if (sync_cnt_cfg_r == 16'h0000) begin
				sync_cnt_r <= 16'h0000; // [R9]
				sync_exp_r <= 1'b0; // [R9]
			end else if (pd_access_ok_i && perm_o.pd_ok) begin
				sync_cnt_r <= 16'h0000; // [R6]
				sync_exp_r <= 1'b0; // [R6]
			end else if (tick && !sync_exp_r) begin
				if (sync_cnt_r + 16'h0001 >= sync_cnt_cfg_r) begin
					sync_exp_r <= 1'b1; // [R3] [R7]
				end else begin
					sync_cnt_r <= sync_cnt_r + 16'h0001;
				end
			end
		end
	end

	// Local-side watchdog; a zero count also switches it off
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			local_cnt_r <= 16'h0000;
			local_exp_r <= 1'b0;
		end else if (clk_en_i) begin
			if (local_cnt_cfg_r == 16'h0000 || local_xchg_i) begin
				local_cnt_r <= 16'h0000;
				local_exp_r <= 1'b0;
			end else if (tick && !local_exp_r) begin
				if (local_cnt_r + 16'h0001 >= local_cnt_cfg_r) begin
					local_exp_r <= 1'b1; // [R8] [R3]
				end else begin
					local_cnt_r <= local_cnt_r + 16'h0001;
				end
			end
		end
	end

	// Slave state machine; failed checks leave the state alone and flag an error
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_r <= SSW_INIT; // [R11]
			err_r <= 1'b0;
		end else if (req_wr) begin
			if (req_code == REQ_INIT) begin
				state_r <= SSW_INIT;
				err_r <= 1'b0;
			end else begin
				unique case (state_r)
					SSW_INIT: begin
						if (req_code == REQ_CONFIG && setup_r[SETUP_MBX_OK]) begin
							state_r <= SSW_CONFIG; // [R13]
							err_r <= 1'b0;
						end else if (req_code == REQ_BOOT && setup_r[SETUP_MBX_OK]) begin
							state_r <= SSW_BOOT; // [R20]
							err_r <= 1'b0;
						end else begin
							err_r <= 1'b1; // [R21]
						end
					end
					SSW_CONFIG: begin
						if (req_code == REQ_INPUTS && setup_r[SETUP_PD_OK] &&
							setup_r[SETUP_DC_OK]) begin
							state_r <= SSW_INPUTS; // [R16]
							err_r <= 1'b0;
						end else if (req_code == REQ_CONFIG) begin
							err_r <= 1'b0;
						end else begin
							err_r <= 1'b1; // [R21]
						end
					end
					SSW_INPUTS: begin
						if (req_code == REQ_FULL) begin
							state_r <= SSW_FULL;
							err_r <= 1'b0;
						end else if (req_code == REQ_CONFIG) begin
							state_r <= SSW_CONFIG;
							err_r <= 1'b0;
						end else begin
							err_r <= 1'b1; // [R21]
						end
					end
					SSW_FULL: begin
						if (req_code == REQ_INPUTS || req_code == REQ_CONFIG) begin
							state_r <= (req_code == REQ_INPUTS) ? SSW_INPUTS : SSW_CONFIG;
							err_r <= 1'b0;
						end else if (req_code != REQ_FULL) begin
							err_r <= 1'b1; // [R21]
						end
					end
					SSW_BOOT: begin
						err_r <= (req_code != REQ_BOOT); // [R20] [R21]
					end
					default: begin
						state_r <= SSW_INIT;
					end
				endcase
			end
		end
	end

	// Field inputs come from pins, so they are synchronised first
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			field_in_s1_r <= '0;
			field_in_s2_r <= '0;
		end else if (clk_en_i) begin
			field_in_s1_r <= field_in_i;
			field_in_s2_r <= field_in_s1_r;
		end
	end

	// Inputs copied on entry to the inputs state and cyclically while exchanging
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dpm_in_r <= '0;
		end else if (clk_en_i) begin
			if ((req_wr && state_r == SSW_CONFIG && req_code == REQ_INPUTS &&
				setup_r[SETUP_PD_OK] && setup_r[SETUP_DC_OK]) ||
				state_r == SSW_INPUTS || state_r == SSW_FULL) begin
				dpm_in_r <= field_in_s2_r; // [R16] [R17]
			end
		end
	end

	// Outputs follow the master in full state with a live watchdog, or in inputs state with sync count zero
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			field_out_r <= '0;
		end else if (clk_en_i) begin
			if (sync_exp_r) begin
				field_out_r <= '0; // [R7]
			end else if (state_r == SSW_FULL) begin
				field_out_r <= master_out_i; // [R19]
			end else if (state_r == SSW_INPUTS && sync_cnt_cfg_r == 16'h0000) begin
				field_out_r <= master_out_i; // [R17] [R9]
			end else begin
				field_out_r <= '0; // [R17]
			end
		end
	end

	// Exchange permissions per state
	always_comb begin
		perm_o = '0;
		unique case (state_r)
			SSW_INIT: perm_o = '0; // [R11]
			SSW_CONFIG: perm_o.mbx_ok = 1'b1; // [R14]
			SSW_INPUTS: begin
				perm_o.mbx_ok = 1'b1; // [R17]
				perm_o.pd_ok = 1'b1;
			end
			SSW_FULL: begin
				perm_o.mbx_ok = 1'b1; // [R19]
				perm_o.pd_ok = 1'b1;
				perm_o.outputs_live = !sync_exp_r;
			end
			SSW_BOOT: perm_o.file_mbx_ok = 1'b1; // [R20]
			default: perm_o = '0;
		endcase
	end

	// Read port; unmapped addresses read zero
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_r <= 32'h00000000;
		end else if (clk_en_i) begin
			rdata_r <= 32'h00000000;
			if (reg_rd_i) begin
				unique case (reg_addr_i)
					REG_PRESCALE: rdata_r <= {16'h0000, prescale_r};
					REG_SYNC_WD: rdata_r <= {16'h0000, sync_cnt_cfg_r};
					REG_LOCAL_WD: rdata_r <= {16'h0000, local_cnt_cfg_r};
					REG_SETUP: rdata_r <= {29'h00000000, setup_r};
					REG_STATUS: begin
						rdata_r[ST_STATE_LSB +: 3] <= state_r;
						rdata_r[ST_ERR] <= err_r; // [R21]
						rdata_r[ST_SYNC_EXP] <= sync_exp_r;
						rdata_r[ST_LOCAL_EXP] <= local_exp_r;
					end
					default: rdata_r <= 32'h00000000;
				endcase
			end
		end
	end

	assign reg_rdata_o = rdata_r;
	assign field_out_o = field_out_r;
	assign dpm_in_o = dpm_in_r;
	assign sync_wd_exp_o = sync_exp_r;
	assign local_wd_exp_o = local_exp_r;
endmodule : ssw_slave_ctrl

// file: tb/ssw_slave_ctrl_assertions.sv
// Port checker for the slave state machine and watchdogs.
// Assumes one clock domain; bound into every ssw_slave_ctrl.
module ssw_slave_ctrl_chk
	import ssw_pkg::*;
#(
	parameter int OUT_W = 8
) (
	// Clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic clk_en_i,
	// Register port
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	// Traffic and data
	input wire logic pd_access_ok_i,
	input wire logic local_xchg_i,
	input wire logic [OUT_W-1:0] master_out_i,
	input wire logic [OUT_W-1:0] field_out_o,
	input wire ssw_perm_t perm_o,
	input wire logic sync_wd_exp_o,
	input wire logic local_wd_exp_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk_i);
	endclocking
	default disable iff (!nrst_i);
	AST_RD_IDLE: assert property ($past(clk_en_i) && !$past(reg_rd_i) |-> reg_rdata_o == '0)
		else $error("read data outside its cycle");
	AST_INIT_BLOCK: assert property ($rose(nrst_i) |-> perm_o == '0)
		else $error("exchange allowed after reset");
	AST_BOOT_ONLY_FILE: assert property (perm_o.file_mbx_ok |-> !perm_o.mbx_ok && !perm_o.pd_ok)
		else $error("boot state allows other traffic");
	AST_SYNC_SAFE: assert property (clk_en_i && sync_wd_exp_o |=> field_out_o == '0)
		else $error("outputs not cleared on sync expiry");
	AST_OUT_GATED: assert property (field_out_o != '0 |-> $past(perm_o.pd_ok))
		else $error("outputs live outside data states");
	AST_OUT_COPY: assert property (clk_en_i && perm_o.outputs_live && !sync_wd_exp_o |=>
		field_out_o == $past(master_out_i))
		else $error("outputs do not follow master data");
	AST_SYNC_CLR: assert property (clk_en_i && pd_access_ok_i && perm_o.pd_ok |=> !sync_wd_exp_o)
		else $error("sync watchdog not restarted");
	AST_LOCAL_CLR: assert property (clk_en_i && local_xchg_i |=> !local_wd_exp_o)
		else $error("local watchdog not restarted");
endmodule : ssw_slave_ctrl_chk

bind ssw_slave_ctrl ssw_slave_ctrl_chk #(.OUT_W(OUT_W)) u_chk (.ref_clk_i(ref_clk_i),
	.nrst_i(nrst_i), .clk_en_i(clk_en_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.pd_access_ok_i(pd_access_ok_i), .local_xchg_i(local_xchg_i),
	.master_out_i(master_out_i), .field_out_o(field_out_o), .perm_o(perm_o),
	.sync_wd_exp_o(sync_wd_exp_o), .local_wd_exp_o(local_wd_exp_o));

// file: tb/ssw_master_model.sv
// Fieldbus master model: process-data accesses and output image.
// Assumes the slave clock; the bench decides when traffic flows.
module ssw_master_model #(
	parameter int OUT_W = 8
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// Bench control
	input wire logic run_i,
	input wire logic [OUT_W-1:0] data_i,
	// Towards the slave
	output logic pd_access_ok_o,
	output logic [OUT_W-1:0] master_out_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Output image is valid before any full exchange request
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			master_out_o <= '0;
			pd_access_ok_o <= 1'b0;
		end else begin
			master_out_o <= data_i;
			pd_access_ok_o <= run_i;
		end
	end
endmodule : ssw_master_model

// file: tb/ssw_slave_ctrl_tb_top.sv
// Bench for the slave state machine and watchdogs.
// Assumes the master model feeds traffic; registers via the plain port.
module ssw_slave_ctrl_tb_top
	import ssw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i, nrst_i, clk_en_i, wr_s, rd_s, lxi, run, pd, sx, lx;
	logic [7:0] adr, fin, mo, fout, dpm;
	logic [31:0] wd, rdat;
	ssw_perm_t perm;
	int n_fail = 0;
	int comparisons = 0;
	int n;
	ssw_slave_ctrl u_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i),
		.reg_addr_i(adr), .reg_wdata_i(wd), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
		.reg_rdata_o(rdat), .pd_access_ok_i(pd), .local_xchg_i(lxi), .master_out_i(mo),
		.field_in_i(fin), .field_out_o(fout), .dpm_in_o(dpm), .perm_o(perm),
		.sync_wd_exp_o(sx), .local_wd_exp_o(lx));
	ssw_master_model u_mst (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .run_i(run),
		.data_i(8'hA5), .pd_access_ok_o(pd), .master_out_o(mo));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected %s exp %h got %h", nm, e, s);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk_i);
		#1;
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		wr_s <= 1'b1;
		adr <= a;
		wd <= d;
		@(posedge ref_clk_i);
		wr_s <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		@(posedge ref_clk_i);
		rd_s <= 1'b1;
		adr <= a;
		@(posedge ref_clk_i);
		rd_s <= 1'b0;
		#1;
		chk(nm, e, rdat);
	endtask : rd
	task automatic st(input logic [2:0] c, input logic [31:0] e);
		wr(REG_STATE_REQ, {29'h0, c});
		rd(REG_STATUS, e, "status");
	endtask : st
	task automatic stop_test();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stop_test
	initial begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end
	// Whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge ref_clk_i);
		n_fail++;
		stop_test();
	end
	initial begin
		nrst_i = 1'b0;
		clk_en_i = 1'b1;
		wr_s = 1'b0;
		rd_s = 1'b0;
		lxi = 1'b0;
		run = 1'b0;
		adr = 8'h00;
		wd = 32'h0;
		fin = 8'h5A;
		repeat (3) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		cyc(1);
		chk("perm", 32'h0, 32'(perm));
		rd(REG_STATUS, 32'h0, "status");
		rd(REG_PRESCALE, 32'h9C2, "prescale");
		rd(REG_SYNC_WD, 32'h3E8, "sync_count");
		rd(REG_LOCAL_WD, 32'h3E8, "local_count");
		rd(8'h20, 32'h0, "unmapped");
		// A prescaler write while the enable is low must leave that register alone
		clk_en_i <= 1'b0;
		wr(REG_PRESCALE, 32'h5);
		clk_en_i <= 1'b1;
		rd(REG_PRESCALE, 32'h9C2, "prescale_frozen");
		wr(REG_PRESCALE, 32'h0);
		rd(REG_PRESCALE, 32'h9C2, "prescale");
		wr(REG_PRESCALE, 32'h1);
		wr(REG_SYNC_WD, 32'hFFFF);
		rd(REG_SYNC_WD, 32'hFFFF, "sync_count");
		st(REQ_CONFIG, 32'h10);
		st(REQ_INPUTS, 32'h10);
		wr(REG_SETUP, 32'h1);
		st(REQ_CONFIG, 32'h1);
		chk("perm", 32'h4, 32'(perm[3:1]));
		st(REQ_BOOT, 32'h11);
		wr(REG_SETUP, 32'h3);
		st(REQ_INPUTS, 32'h11);
		wr(REG_SETUP, 32'h7);
		run <= 1'b1;
		st(REQ_INPUTS, 32'h2);
		cyc(4);
		chk("dpm_in", 32'h5A, 32'(dpm));
		chk("perm", 32'h5, 32'(perm[3:1]));
		chk("field_out", 32'h0, 32'(fout));
		st(REQ_FULL, 32'h3);
		wr(REG_SYNC_WD, 32'h2);
		cyc(8);
		chk("field_out", 32'hA5, 32'(fout));
		chk("sync_exp", 32'h0, 32'(sx));
		@(posedge ref_clk_i);
		run <= 1'b0;
		n = 0;
		while (sx !== 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		// Tick is prescale plus two cycles, two ticks to expiry
		chk("sync_delay", 32'h1, 32'(n >= 5 && n <= 8));
		cyc(1);
		chk("field_out", 32'h0, 32'(fout));
		rd(REG_STATUS, 32'h23, "status");
		@(posedge ref_clk_i);
		run <= 1'b1;
		cyc(3);
		chk("sync_exp", 32'h0, 32'(sx));
		wr(REG_SYNC_WD, 32'h0);
		run <= 1'b0;
		cyc(20);
		chk("sync_exp", 32'h0, 32'(sx));
		st(REQ_INPUTS, 32'h2);
		cyc(2);
		chk("field_out", 32'hA5, 32'(fout));
		wr(REG_LOCAL_WD, 32'h2);
		cyc(12);
		chk("local_exp", 32'h1, 32'(lx));
		@(posedge ref_clk_i);
		lxi <= 1'b1;
		@(posedge ref_clk_i);
		lxi <= 1'b0;
		#1;
		chk("local_exp", 32'h0, 32'(lx));
		wr(REG_LOCAL_WD, 32'h0);
		st(REQ_INIT, 32'h0);
		st(REQ_BOOT, 32'h4);
		chk("perm", 32'h2, 32'(perm[3:1]));
		stop_test();
	end
endmodule : ssw_slave_ctrl_tb_top
